// >>> src/epo_cfg.svh
// constants of the energy pulse output block
`ifndef EPO_CFG_SVH
`define EPO_CFG_SVH
`define EPO_CLK_PERIOD_NS 10
`define EPO_OFF_LED_MODE  8'h00
`define EPO_OFF_RATE      8'h04
`define EPO_OFF_CHANNEL   8'h08
`define EPO_OFF_DOUT_MODE 8'h0C
`define EPO_OFF_DOUT_EXT  8'h10
`define EPO_OFF_COUNT     8'h14
`define EPO_OFF_STATUS    8'h18
`define EPO_RATE_MIN      24'h00_0001
`define EPO_RATE_MAX      24'h98_967F
`define EPO_RATE_RST      24'h00_03E8
`define EPO_CH_MAX        4'h8
`define EPO_CH_RST        4'h0
`define EPO_LED_RST       2'h2
`define EPO_STRAP_WAIT    2'h2
`define EPO_UNIT_PER_KWH  48'h0000_000F_4240
`define EPO_PULSE_ON_MS   50
`define EPO_PULSE_ON_CYC ((`EPO_PULSE_ON_MS * 1000000) / `EPO_CLK_PERIOD_NS)
`endif

// >>> src/epo_pkg.sv
// types shared by the energy pulse output block
package epo_pkg;
  typedef enum logic [1:0] {
    EPO_LED_OFF    = 2'h0,
    EPO_LED_ALARM  = 2'h1,
    EPO_LED_ENERGY = 2'h2
  } epo_led_mode_t;
  typedef enum logic [2:0] {
    EPO_ST_IDLE = 3'b001,
    EPO_ST_ON   = 3'b010,
    EPO_ST_GAP  = 3'b100
  } epo_pulse_st_t;
endpackage : epo_pkg

// >>> src/epo_accum.sv
// energy accumulator that turns weighted increments into unit pulses
`timescale 1ns/1ps
`default_nettype none
`include "epo_cfg.svh"
module epo_accum import epo_pkg::*; #(
  parameter int INC_W  = 17,
  parameter int RATE_W = 24,
  parameter int ACC_W  = 48
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // energy side
  input  wire logic              run,
  input  wire logic              inc_valid,
  input  wire logic [INC_W-1:0]  inc,
  input  wire logic [RATE_W-1:0] rate,
  // pulse request
  output logic                   pulse
);
  localparam logic [ACC_W-1:0] UNIT = `EPO_UNIT_PER_KWH;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] add;
  logic [ACC_W-1:0] next_acc;
  logic             hit;

  // increment weighted by pulses per unit, so one unit of sum is one pulse
  // both factors widened first so the product is never cut to the rate width
  assign add = inc_valid ? (ACC_W'(inc) * ACC_W'(rate)) : '0;
  assign hit = acc >= UNIT;
  assign next_acc = acc + add - (hit ? UNIT : '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc   <= '0;
      pulse <= 1'b0;
    end else if (!run) begin
      acc   <= '0;
      pulse <= 1'b0;
    end else begin
      acc   <= next_acc;
      pulse <= hit;
    end
  end

  property p_unit_pulse;
    @(posedge hclk) disable iff (!hresetn)
    (run && hit) |=> (pulse && acc == $past(acc) + $past(add) - UNIT);
  endproperty
  a_unit_pulse: assert property (p_unit_pulse) else $error("unit reached without pulse");

  property p_no_pulse;
    @(posedge hclk) disable iff (!hresetn)
    (acc < UNIT) |=> !pulse;
  endproperty
  a_no_pulse: assert property (p_no_pulse) else $error("pulse below one unit");
endmodule : epo_accum
`default_nettype wire

// >>> src/epo_pulse.sv
// pulse shaper: fixed on time, gap one cycle longer, pending requests counted
`timescale 1ns/1ps
`default_nettype none
module epo_pulse import epo_pkg::*; #(
  parameter int ON_CYC = 5000000,
  parameter int PEND_W = 16
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // request and shaped train
  input  wire logic run,
  input  wire logic req,
  output logic      train
);
  epo_pulse_st_t     st;
  logic [31:0]       cnt;
  logic [PEND_W-1:0] pend;
  logic              take;

  assign take = (st == EPO_ST_IDLE) && (pend != '0);

  // requests arriving while a pulse runs wait here; once the count saturates at all ones, further ones are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= '0;
    end else if (!run) begin
      pend <= '0;
    end else if (req && !take && pend != '1) begin
      pend <= pend + 1'b1;
    end else if (!req && take) begin
      pend <= pend - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st    <= EPO_ST_IDLE;
      cnt   <= '0;
      train <= 1'b0;
    end else if (!run) begin
      st    <= EPO_ST_IDLE;
      cnt   <= '0;
      train <= 1'b0;
    end else begin
      case (st)
        EPO_ST_IDLE: begin
          if (take) begin
            st    <= EPO_ST_ON;
            cnt   <= 32'(ON_CYC - 1);
            train <= 1'b1;
          end
        end
        EPO_ST_ON: begin
          if (cnt == '0) begin
            st    <= EPO_ST_GAP;
            cnt   <= 32'(ON_CYC - 1);
            train <= 1'b0;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        EPO_ST_GAP: begin
          if (cnt == '0) begin
            st <= EPO_ST_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          st    <= EPO_ST_IDLE;
          train <= 1'b0;
        end
      endcase
    end
  end

  property p_on_level;
    @(posedge hclk) disable iff (!hresetn)
    $rose(train) |-> (st == EPO_ST_ON && cnt == 32'(ON_CYC - 1));
  endproperty
  a_on_level: assert property (p_on_level) else $error("pulse started off count");
endmodule : epo_pulse
`default_nettype wire

// >>> src/epo_top.sv
// energy pulse output: register slave, channel select, LED and digital outputs
`timescale 1ns/1ps
`default_nettype none
`include "epo_cfg.svh"
// What this block does
// - LED function is off, alarm indication, or energy pulsing.
// - energy mode gives 1 to 9999999 pulses per unit of energy.
// - alarm mode ignores pulse rate and channel selection.
// - nine channels: active, reactive, apparent; delivered, received, or both.
// - fixed variant keeps LED in energy pulsing, refusing off or alarm.
// - digital output energy mode attaches pulsing; external mode detaches it.
// - each pulse comes from measured energy, usable for verification counting.
module epo_top import epo_pkg::*; #(
  parameter int NUM_DOUT = 2,
  parameter int INC_W    = 16,
  parameter int ON_CYC   = `EPO_PULSE_ON_CYC
) (
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // metering engine increments, order active, reactive, apparent
  input  wire logic                  eng_inc_valid,
  input  wire logic [3*INC_W-1:0]    eng_del_inc,
  input  wire logic [3*INC_W-1:0]    eng_rec_inc,
  // alarm system level
  input  wire logic                  alarm_active,
  // product variant strap pin
  input  wire logic                  fixed_energy_pin,
  // outputs
  output logic                       led_out,
  output logic [NUM_DOUT-1:0]        dout
);
  epo_led_mode_t       led_mode;
  logic [23:0]         rate;
  logic [3:0]          channel;
  logic [NUM_DOUT-1:0] dout_mode;
  logic [NUM_DOUT-1:0] dout_ext;
  logic [31:0]         pulse_count;
  logic                fixed_lock;
  logic                strap_done;
  logic [1:0]          strap_wait;
  logic                strap_s1;
  logic                strap_s2;
  logic                wr_pend;
  logic [7:0]          wr_addr;
  logic                addr_ok;
  logic [31:0]         next_rdata;
  logic [INC_W:0]      sel_inc;
  logic                energy_run;
  logic                acc_pulse;
  logic                train;

  // ---------------- bus slave: zero wait state ----------------
  assign addr_ok = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_comb begin
    next_rdata = '0;
    case (haddr[7:0])
      `EPO_OFF_LED_MODE:  next_rdata = {30'h0000_0000, led_mode};
      `EPO_OFF_RATE:      next_rdata = {8'h00, rate};
      `EPO_OFF_CHANNEL:   next_rdata = {28'h000_0000, channel};
      `EPO_OFF_DOUT_MODE: next_rdata = 32'(dout_mode);
      `EPO_OFF_DOUT_EXT:  next_rdata = 32'(dout_ext);
      `EPO_OFF_COUNT:     next_rdata = pulse_count;
      `EPO_OFF_STATUS:    next_rdata = {29'h0000_0000, train, energy_run, fixed_lock};
      default:            next_rdata = '0;
    endcase
  end

  // read data captured at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= '0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= (addr_ok && !hwrite) ? next_rdata : '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ---------------- variant strap ----------------
  // strap is a pin, so it crosses two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end else begin
      strap_s1 <= fixed_energy_pin;
      strap_s2 <= strap_s1;
    end
  end

  // ---------------- led function ----------------
  // the strap is caught once after release; later pin changes are ignored
  // mode writes that arrive before the capture are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_mode   <= epo_led_mode_t'(`EPO_LED_RST);
      fixed_lock <= 1'b0;
      strap_done <= 1'b0;
      strap_wait <= 2'h0;
    end else if (!strap_done) begin
      // sync flops restart at zero, so wait until the pin level has reached the second one
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == `EPO_STRAP_WAIT) begin
        strap_done <= 1'b1;
        fixed_lock <= strap_s2;
        if (strap_s2) begin
          led_mode <= EPO_LED_ENERGY;
        end
      end
    end else if (wr_pend && wr_addr == `EPO_OFF_LED_MODE) begin
      if (hwdata[1:0] == EPO_LED_ENERGY) begin
        led_mode <= EPO_LED_ENERGY;
      end else if (!fixed_lock && hwdata[1:0] == EPO_LED_OFF) begin
        led_mode <= EPO_LED_OFF;
      end else if (!fixed_lock && hwdata[1:0] == EPO_LED_ALARM) begin
        led_mode <= EPO_LED_ALARM;
      end
    end
  end

  // ---------------- pulse rate and channel ----------------
  // out-of-range writes leave the old value so the setting stays legal
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate <= `EPO_RATE_RST;
    end else if (wr_pend && wr_addr == `EPO_OFF_RATE &&
                 hwdata[31:24] == 8'h00 &&
                 hwdata[23:0] >= `EPO_RATE_MIN &&
                 hwdata[23:0] <= `EPO_RATE_MAX) begin
      rate <= hwdata[23:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel <= `EPO_CH_RST;
    end else if (wr_pend && wr_addr == `EPO_OFF_CHANNEL &&
                 hwdata[31:4] == 28'h000_0000 && hwdata[3:0] <= `EPO_CH_MAX) begin
      channel <= hwdata[3:0];
    end
  end

  // ---------------- digital output settings ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout_mode <= '0;
      dout_ext  <= '0;
    end else if (wr_pend) begin
      if (wr_addr == `EPO_OFF_DOUT_MODE) begin
        dout_mode <= hwdata[NUM_DOUT-1:0];
      end
      if (wr_addr == `EPO_OFF_DOUT_EXT) begin
        dout_ext <= hwdata[NUM_DOUT-1:0];
      end
    end
  end

  // ---------------- channel selection ----------------
  // quantity and direction
  always_comb begin
    sel_inc = '0;
    case (channel)
      4'h0: sel_inc = {1'b0, eng_del_inc[0*INC_W +: INC_W]};
      4'h1: sel_inc = {1'b0, eng_rec_inc[0*INC_W +: INC_W]};
      4'h2: sel_inc = eng_del_inc[0*INC_W +: INC_W] + eng_rec_inc[0*INC_W +: INC_W];
      4'h3: sel_inc = {1'b0, eng_del_inc[1*INC_W +: INC_W]};
      4'h4: sel_inc = {1'b0, eng_rec_inc[1*INC_W +: INC_W]};
      4'h5: sel_inc = eng_del_inc[1*INC_W +: INC_W] + eng_rec_inc[1*INC_W +: INC_W];
      4'h6: sel_inc = {1'b0, eng_del_inc[2*INC_W +: INC_W]};
      4'h7: sel_inc = {1'b0, eng_rec_inc[2*INC_W +: INC_W]};
      4'h8: sel_inc = eng_del_inc[2*INC_W +: INC_W] + eng_rec_inc[2*INC_W +: INC_W];
      default: sel_inc = '0;
    endcase
  end

  assign energy_run = (led_mode == EPO_LED_ENERGY) || (dout_mode != '0);

  epo_accum #(
    .INC_W  (INC_W + 1),
    .RATE_W (24),
    .ACC_W  (48)
  ) u_accum (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .run       (energy_run),
    .inc_valid (eng_inc_valid),
    .inc       (sel_inc),
    .rate      (rate),
    .pulse     (acc_pulse)
  );

  epo_pulse #(
    .ON_CYC (ON_CYC),
    .PEND_W (16)
  ) u_pulse (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (energy_run),
    .req     (acc_pulse),
    .train   (train)
  );

  // count of pulse requests from the accumulator, for software cross-checking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_count <= '0;
    end else if (acc_pulse) begin
      pulse_count <= pulse_count + 1'b1;
    end
  end

  // ---------------- output drivers ----------------
  // led by function
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_out <= 1'b0;
    end else begin
      case (led_mode)
        EPO_LED_OFF:    led_out <= 1'b0;
        EPO_LED_ALARM:  led_out <= alarm_active;
        EPO_LED_ENERGY: led_out <= train;
        default:        led_out <= 1'b0;
      endcase
    end
  end

  for (genvar i = 0; i < NUM_DOUT; i++) begin : g_dout
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        dout[i] <= 1'b0;
      end else begin
        dout[i] <= dout_mode[i] ? train : dout_ext[i];
      end
    end
  end

  // ---------------- checks ----------------
  property p_led_off;
    @(posedge hclk) disable iff (!hresetn)
    (led_mode == EPO_LED_OFF) |=> !led_out;
  endproperty
  a_led_off: assert property (p_led_off) else $error("led lit while off");

  property p_led_alarm;
    @(posedge hclk) disable iff (!hresetn)
    (led_mode == EPO_LED_ALARM) |=> (led_out == $past(alarm_active));
  endproperty
  a_led_alarm: assert property (p_led_alarm) else $error("led not following alarm");

  property p_led_energy;
    @(posedge hclk) disable iff (!hresetn)
    (led_mode == EPO_LED_ENERGY) |=> (led_out == $past(train));
  endproperty
  a_led_energy: assert property (p_led_energy) else $error("led not pulsing");

  property p_fixed;
    @(posedge hclk) disable iff (!hresetn)
    fixed_lock |-> (led_mode == EPO_LED_ENERGY);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed variant left energy");

  property p_rate;
    @(posedge hclk) disable iff (!hresetn)
    (rate >= `EPO_RATE_MIN) && (rate <= `EPO_RATE_MAX);
  endproperty
  a_rate: assert property (p_rate) else $error("pulse rate out of range");

  property p_channel;
    @(posedge hclk) disable iff (!hresetn)
    channel <= `EPO_CH_MAX;
  endproperty
  a_channel: assert property (p_channel) else $error("channel out of range");

  property p_dout_sel;
    @(posedge hclk) disable iff (!hresetn)
    1'b1 |=> (dout[0] == ($past(dout_mode[0]) ? $past(train) : $past(dout_ext[0])));
  endproperty
  a_dout_sel: assert property (p_dout_sel) else $error("digital output source wrong");
endmodule : epo_top
`default_nettype wire

// >>> verification/epo_pulse_counter.sv
// far-side pulse counter that tallies pulses and checks their shape
`timescale 1ns/1ps
`default_nettype none
module epo_pulse_counter #(
  parameter int ON_CYC = 8
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // observed line
  input  wire logic enable,
  input  wire logic line,
  // tallies
  output int        n_pulse,
  output int        n_bad
);
  logic prev;
  int   hi_len;
  int   lo_len;
  // fixed width, gap at least as long
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev    <= 1'b0;
      hi_len  <= 0;
      lo_len  <= ON_CYC;
      n_pulse <= 0;
      n_bad   <= 0;
    end else begin
      prev   <= line;
      hi_len <= line ? hi_len + 1 : 0;
      lo_len <= line ? 0 : lo_len + 1;
      if (enable && line && !prev) begin
        n_pulse <= n_pulse + 1;
        if (lo_len < ON_CYC) begin
          n_bad <= n_bad + 1;
        end
      end
      if (enable && !line && prev && hi_len != ON_CYC) begin
        n_bad <= n_bad + 1;
      end
    end
  end
endmodule : epo_pulse_counter
`default_nettype wire

// >>> verification/tb_energy_pulse_output.sv
// bench: registers, pulses per channel, alarm, off, external, fixed variant
`timescale 1ns/1ps
`default_nettype none
`include "epo_cfg.svh"
module tb_energy_pulse_output;
  import epo_pkg::*;
  localparam int ON = 8;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        eng_inc_valid = 1'b0;
  logic [47:0] eng_del_inc = 48'h0000_0000_0000;
  logic [47:0] eng_rec_inc = 48'h0000_0000_0000;
  logic        alarm_active = 1'b0;
  logic        fixed_energy_pin = 1'b0;
  logic        led_out;
  logic [1:0]  dout;
  logic        en_led = 1'b1;
  logic        en_dout = 1'b0;
  logic        run = 1'b1;
  int          led_n, led_bad, do_n, do_bad;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          seed = 32'h000e_2b83;
  int          exp_cnt = 0;
  longint      acc = 0;
  longint      rate = 1000;
  logic [31:0] q;

  always #5 hclk = ~hclk;

  epo_top #(.ON_CYC(ON)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .eng_inc_valid(eng_inc_valid), .eng_del_inc(eng_del_inc), .eng_rec_inc(eng_rec_inc),
    .alarm_active(alarm_active), .fixed_energy_pin(fixed_energy_pin),
    .led_out(led_out), .dout(dout)
  );
  epo_pulse_counter #(.ON_CYC(ON)) u_led (
    .hclk(hclk), .hresetn(hresetn), .enable(en_led), .line(led_out),
    .n_pulse(led_n), .n_bad(led_bad)
  );
  epo_pulse_counter #(.ON_CYC(ON)) u_dout (
    .hclk(hclk), .hresetn(hresetn), .enable(en_dout), .line(dout[0]),
    .n_pulse(do_n), .n_bad(do_bad)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    // read data as it stood during the data phase, taken at its closing edge
    q = hrdata;
  endtask : bus

  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wrt

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask : rdc

  // model: weighted increments build up, one pulse per whole unit
  task automatic feed(input int ch, input int n);
    logic [47:0] d;
    logic [47:0] r;
    longint      sel;
    for (int k = 0; k < n; k++) begin
      d = {16'($random(seed) & 3), 16'($random(seed) & 3), 16'($random(seed) & 3)};
      r = {16'($random(seed) & 3), 16'($random(seed) & 3), 16'($random(seed) & 3)};
      sel = (ch % 3 != 1 ? d[(ch / 3) * 16 +: 16] : 0) + (ch % 3 != 0 ? r[(ch / 3) * 16 +: 16] : 0);
      acc = run ? acc + sel * rate : 0;
      exp_cnt += int'(acc / 1000000);
      acc = acc % 1000000;
      @(posedge hclk);
      eng_del_inc   <= d;
      eng_rec_inc   <= r;
      eng_inc_valid <= 1'b1;
      @(posedge hclk);
      eng_inc_valid <= 1'b0;
    end
  endtask : feed

  task automatic settle();
    int t;
    t = 0;
    while (led_n != exp_cnt && t < 3000) begin
      @(posedge hclk);
      t++;
    end
    if (t >= 3000) begin
      n_mismatch++;
      $display("MISMATCH %0t pulses still outstanding", $time);
    end
    repeat (2 * ON + 4) @(posedge hclk);
  endtask : settle

  task automatic results();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    rdc(`EPO_OFF_LED_MODE, 32'h0000_0002);
    rdc(`EPO_OFF_RATE, 32'h0000_03E8);
    rdc(`EPO_OFF_CHANNEL, 32'h0000_0000);
    rdc(`EPO_OFF_DOUT_MODE, 32'h0000_0000);
    rdc(8'h1C, 32'h0000_0000);
    wrt(`EPO_OFF_RATE, 32'h0000_0000);
    rdc(`EPO_OFF_RATE, 32'h0000_03E8);
    wrt(`EPO_OFF_RATE, 32'h0098_9680);
    rdc(`EPO_OFF_RATE, 32'h0000_03E8);
    wrt(`EPO_OFF_CHANNEL, 32'h0000_0009);
    rdc(`EPO_OFF_CHANNEL, 32'h0000_0000);
    wrt(`EPO_OFF_LED_MODE, 32'h0000_0003);
    rdc(`EPO_OFF_LED_MODE, 32'h0000_0002);
    wrt(`EPO_OFF_COUNT, 32'h0000_0005);
    rdc(`EPO_OFF_COUNT, 32'h0000_0000);
    wrt(`EPO_OFF_DOUT_MODE, 32'h0000_0001);
    wrt(`EPO_OFF_DOUT_EXT, 32'h0000_0002);
    en_dout <= 1'b1;
    for (int ch = 0; ch < 9; ch++) begin
      rate = (ch == 4) ? 9999999 : (ch == 2) ? 1 : 1 + ($random(seed) & 32'h0003_FFFF);
      wrt(`EPO_OFF_CHANNEL, 32'(ch));
      wrt(`EPO_OFF_RATE, 32'(rate));
      feed(ch, (ch == 4) ? 1 : 6);
      settle();
      rdc(`EPO_OFF_COUNT, 32'(exp_cnt));
      chk(32'(led_n), 32'(exp_cnt));
      chk(32'(do_n), 32'(exp_cnt));
      chk(32'(led_bad + do_bad), 32'h0000_0000);
      chk({31'h0000_0000, dout[1]}, 32'h0000_0001);
    end
    // no user left in energy mode, so nothing may accumulate
    wrt(`EPO_OFF_DOUT_MODE, 32'h0000_0000);
    wrt(`EPO_OFF_LED_MODE, 32'h0000_0001);
    en_led <= 1'b0;
    en_dout <= 1'b0;
    run = 1'b0;
    wrt(`EPO_OFF_RATE, 32'h0000_0001);
    wrt(`EPO_OFF_CHANNEL, 32'h0000_0005);
    rdc(`EPO_OFF_CHANNEL, 32'h0000_0005);
    feed(5, 3);
    for (int k = 0; k < 8; k++) begin
      alarm_active <= 1'($random(seed));
      repeat (4) @(posedge hclk);
      chk({31'h0000_0000, led_out}, {31'h0000_0000, alarm_active});
    end
    rdc(`EPO_OFF_COUNT, 32'(exp_cnt));
    wrt(`EPO_OFF_LED_MODE, 32'h0000_0000);
    alarm_active <= 1'b1;
    wrt(`EPO_OFF_DOUT_EXT, 32'h0000_0001);
    repeat (4) @(posedge hclk);
    chk({31'h0000_0000, led_out}, 32'h0000_0000);
    chk({30'h0000_0000, dout}, 32'h0000_0001);
    hresetn <= 1'b0;
    fixed_energy_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    wrt(`EPO_OFF_LED_MODE, 32'h0000_0000);
    rdc(`EPO_OFF_LED_MODE, 32'h0000_0002);
    wrt(`EPO_OFF_LED_MODE, 32'h0000_0001);
    rdc(`EPO_OFF_LED_MODE, 32'h0000_0002);
    rdc(`EPO_OFF_STATUS, 32'h0000_0003);
    results();
  end

  // watchdog sized well above the longest settle sequence
  initial begin
    repeat (60000) @(posedge hclk);
    n_mismatch++;
    results();
  end
endmodule : tb_energy_pulse_output
`default_nettype wire
